// File: verilog/pbk_pkg.sv
package pbk_pkg;

  // ==========================================================
  // Port geometry
  localparam int PBK_NUM_PORTS = 11;
  localparam int PBK_WIDTH = 8;
  localparam int PBK_TOTAL_PINS = 85;
  localparam int PBK_P2 = 2;
  localparam int PBK_P3 = 3;
  localparam int PBK_P4 = 4;
  localparam int PBK_P5 = 5;
  localparam int PBK_P6 = 6;
  localparam int PBK_P7 = 7;
  localparam int PBK_P8 = 8;
  localparam int PBK_P9 = 9;
  localparam int PBK_PA = 10;

  // ==========================================================
  // Register offsets, index = port number (A = 10)
  localparam logic [7:0] PBK_DATA_OFS [0:10] = '{
    8'h00, 8'h02, 8'h04, 8'h0C, 8'h0E, 8'h10, 8'h12, 8'h14, 8'h16, 8'h18, 8'h1A};
  localparam logic [7:0] PBK_DIR_OFS [0:10] = '{
    8'h01, 8'h03, 8'hFF, 8'h0D, 8'hFF, 8'hFF, 8'h13, 8'h15, 8'hFF, 8'h19, 8'h1B};
  // Ports that own a direction register
  localparam logic [10:0] PBK_HAS_DIR = 11'b110_1100_1011;
  // Direction registers that read back (ports 0 and 1 are write-only)
  localparam logic [10:0] PBK_DIR_READABLE = 11'b110_1100_1000;

  // ==========================================================
  // Field masks and reset values
  localparam logic [7:0] PBK_DIR_RESET = 8'h00;
  localparam logic [7:0] PBK_FULL_MASK = 8'hFF;
  localparam logic [7:0] PBK_PORT4_MASK = 8'h1F;
  localparam logic [7:0] PBK_RDATA_IDLE = 8'h00;
  // Pins a peripheral may drive, per port
  localparam logic [7:0] PBK_PERIPH_MASK [0:10] = '{
    8'h00, 8'h00, 8'h00, 8'hA7, 8'h00, 8'h00, 8'hA5, 8'h2D, 8'h00, 8'h00, 8'h00};

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic bit_op;
  } pbk_req_t;

  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
  } pbk_drive_t;

endpackage : pbk_pkg

// File: verilog/pbk_port_bank.sv
`timescale 1ns/1ps
module pbk_port_bank (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rstn_in,
  // Register port
  input wire pbk_pkg::pbk_req_t req_in,
  output logic [7:0] rdata_out,
  // Pads: level seen, level driven, driver enable
  input wire logic [10:0][7:0] pin_in,
  output logic [10:0][7:0] pin_out,
  output logic [10:0][7:0] pin_oe_out,
  // Peripheral drive requests for shared pins
  input wire logic [10:0][7:0] periph_sel_in,
  input wire logic [10:0][7:0] periph_dout_in,
  input wire logic [7:0] analog_channel_sel_in,
  // Synchronised pin levels towards peripherals
  output logic [10:0][7:0] pin_sync_out,
  output logic serial_a_in_out,
  output logic serial_b_in_out,
  output logic buffered_serial_a_in_out,
  output logic buffered_serial_b_in_out,
  output logic counter_ext_clock_out,
  output logic [15:0] level_irq_out,
  output logic [7:0] edge_irq_out
);

  // ==========================================================
  // Storage
  logic [7:0] latch [0:10];
  logic [7:0] direction [0:10];
  logic [10:0][7:0] sync_a;
  logic [10:0][7:0] sync_b;
  logic [7:0] next_rdata;
  pbk_pkg::pbk_drive_t drive [0:10];

  // ==========================================================
  // Input synchronisers: the first stage feeds only the second
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= pin_in;
      sync_b <= sync_a;
    end
  end

  // ==========================================================
  // Per-port latch, direction and pin drive
  genvar p;
  generate
    for (p = 0; p < pbk_pkg::PBK_NUM_PORTS; p++) begin : g_port
      // Latches keep no reset so software sees the documented undefined state
      always_ff @(posedge core_clk_in) begin
        if (req_in.wr && req_in.addr == pbk_pkg::PBK_DATA_OFS[p]) begin
          latch[p] <= req_in.wdata;
        end
      end

      if (pbk_pkg::PBK_HAS_DIR[p]) begin : g_dir
        always_ff @(posedge core_clk_in or negedge rstn_in) begin
          if (!rstn_in) begin
            direction[p] <= pbk_pkg::PBK_DIR_RESET;
          end else if (req_in.wr && req_in.addr == pbk_pkg::PBK_DIR_OFS[p]) begin
            direction[p] <= req_in.wdata;
          end
        end
      end else begin : g_nodir
        // Ports without a direction register: driver on, except port 4 pins 5-7 and port 5 pins held by an analog channel
        assign direction[p] = pbk_pkg::PBK_FULL_MASK;
      end

      always_comb begin
        drive[p].dout = latch[p];
        drive[p].oe = direction[p];
        // Shared pins: an active peripheral overrides the latch
        drive[p].dout = (periph_dout_in[p] & periph_sel_in[p] & pbk_pkg::PBK_PERIPH_MASK[p])
          | (latch[p] & ~(periph_sel_in[p] & pbk_pkg::PBK_PERIPH_MASK[p]));
        drive[p].oe = direction[p] | (periph_sel_in[p] & pbk_pkg::PBK_PERIPH_MASK[p]);
        if (p == pbk_pkg::PBK_P4) begin
          drive[p].oe = pbk_pkg::PBK_PORT4_MASK;
        end
        if (p == pbk_pkg::PBK_P5) begin
          // An analog channel in use must not fight the driver
          drive[p].oe = ~analog_channel_sel_in;
        end
      end

      assign pin_out[p] = drive[p].dout;
      assign pin_oe_out[p] = drive[p].oe;
    end
  endgenerate

  // ==========================================================
  // Register read, answered one cycle later
  always_comb begin
    next_rdata = pbk_pkg::PBK_RDATA_IDLE;
    for (int i = 0; i < pbk_pkg::PBK_NUM_PORTS; i++) begin
      if (req_in.addr == pbk_pkg::PBK_DATA_OFS[i]) begin
        if (pbk_pkg::PBK_HAS_DIR[i] && !req_in.bit_op) begin
          next_rdata = sync_b[i];
        end else begin
          // Bit operations and output-only ports see the latch
          next_rdata = latch[i];
        end
        if (i == pbk_pkg::PBK_P4) begin
          next_rdata = latch[i] & pbk_pkg::PBK_PORT4_MASK;
        end
      end
      if (pbk_pkg::PBK_DIR_READABLE[i] && req_in.addr == pbk_pkg::PBK_DIR_OFS[i]) begin
        next_rdata = direction[i];
      end
    end
    // Ports 0/1 direction and unmapped addresses fall through as zero
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_out <= pbk_pkg::PBK_RDATA_IDLE;
    end else if (req_in.rd) begin
      rdata_out <= next_rdata;
    end else begin
      rdata_out <= pbk_pkg::PBK_RDATA_IDLE;
    end
  end

  // ==========================================================
  // Pin levels towards peripherals
  assign pin_sync_out = sync_b;
  assign serial_a_in_out = sync_b[pbk_pkg::PBK_P3][6];
  assign buffered_serial_a_in_out = sync_b[pbk_pkg::PBK_P6][6];
  assign counter_ext_clock_out = sync_b[pbk_pkg::PBK_P6][1];
  assign serial_b_in_out = sync_b[pbk_pkg::PBK_P7][1];
  assign buffered_serial_b_in_out = sync_b[pbk_pkg::PBK_P7][4];
  assign level_irq_out = {sync_b[pbk_pkg::PBK_PA], sync_b[pbk_pkg::PBK_P9]};
  assign edge_irq_out = sync_b[pbk_pkg::PBK_PA];

  // ==========================================================
  // Checks
  // Direction registers
  dir_write_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (req_in.wr && req_in.addr == pbk_pkg::PBK_DIR_OFS[0])
    |=> pin_oe_out[0] == $past(req_in.wdata))
    else $error("port 0 driver enable does not follow direction write");

  dir_write_p1_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (req_in.wr && req_in.addr == pbk_pkg::PBK_DIR_OFS[1])
    |=> pin_oe_out[1] == $past(req_in.wdata))
    else $error("port 1 driver enable does not follow direction write");

  dir_write_p3_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (req_in.wr && req_in.addr == pbk_pkg::PBK_DIR_OFS[3])
    |=> direction[3] == $past(req_in.wdata))
    else $error("port 3 direction write lost");

  dir_write_p6_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (req_in.wr && req_in.addr == pbk_pkg::PBK_DIR_OFS[6])
    |=> direction[6] == $past(req_in.wdata))
    else $error("port 6 direction write lost");

  dir_write_p7_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (req_in.wr && req_in.addr == pbk_pkg::PBK_DIR_OFS[7])
    |=> direction[7] == $past(req_in.wdata))
    else $error("port 7 direction write lost");

  dir_write_p9_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (req_in.wr && req_in.addr == pbk_pkg::PBK_DIR_OFS[9])
    |=> direction[9] == $past(req_in.wdata))
    else $error("port 9 direction write lost");

  dir_write_pa_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (req_in.wr && req_in.addr == pbk_pkg::PBK_DIR_OFS[10])
    |=> direction[10] == $past(req_in.wdata))
    else $error("port A direction write lost");

  dir_read_p3_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (req_in.rd && req_in.addr == pbk_pkg::PBK_DIR_OFS[3])
    |=> rdata_out == $past(direction[3]))
    else $error("port 3 direction register does not read back");

  dir_read_p9_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (req_in.rd && req_in.addr == pbk_pkg::PBK_DIR_OFS[9])
    |=> rdata_out == $past(direction[9]))
    else $error("port 9 direction register does not read back");

  dir_read_pa_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (req_in.rd && req_in.addr == pbk_pkg::PBK_DIR_OFS[10])
    |=> rdata_out == $past(direction[10]))
    else $error("port A direction register does not read back");

  dir_reset_a: assert property (@(posedge core_clk_in)
    $rose(rstn_in) |-> pin_oe_out[0] == 8'h00 && pin_oe_out[9] == 8'h00
    && pin_oe_out[10] == 8'h00)
    else $error("bidirectional pins drive straight after reset");

  dir_reset_all_a: assert property (@(posedge core_clk_in)
    $rose(rstn_in) |-> direction[0] == 8'h00 && direction[1] == 8'h00
    && direction[3] == 8'h00 && direction[6] == 8'h00 && direction[7] == 8'h00
    && direction[9] == 8'h00 && direction[10] == 8'h00)
    else $error("direction register not clear after reset");

  dir_hold_reset_a: assert property (@(posedge core_clk_in)
    !rstn_in |-> direction[3] == 8'h00 && direction[6] == 8'h00
    && direction[9] == 8'h00 && direction[10] == 8'h00)
    else $error("direction register not cleared while reset is held");

  // Output-only and analog ports
  port2_drive_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    pin_oe_out[2] == 8'hFF && pin_oe_out[8] == 8'hFF)
    else $error("output-only port 2 or 8 not driving");

  port2_pin_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (req_in.wr && req_in.addr == pbk_pkg::PBK_DATA_OFS[2])
    |=> pin_out[2] == $past(req_in.wdata))
    else $error("port 2 pins do not follow write");

  port4_drive_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    pin_oe_out[4] == 8'h1F)
    else $error("port 4 driver enable wrong");

  port4_width_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (req_in.rd && req_in.addr == pbk_pkg::PBK_DATA_OFS[4])
    |=> rdata_out[7:5] == 3'b000 && pin_oe_out[4] == 8'h1F)
    else $error("port 4 upper bits visible");

  port4_pin_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (req_in.wr && req_in.addr == pbk_pkg::PBK_DATA_OFS[4])
    |=> pin_out[4][4:0] == $past(req_in.wdata[4:0]))
    else $error("port 4 pins do not follow write");

  port5_pin_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (req_in.wr && req_in.addr == pbk_pkg::PBK_DATA_OFS[5])
    |=> pin_out[5] == $past(req_in.wdata))
    else $error("port 5 pins do not follow write");

  port8_pin_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (req_in.wr && req_in.addr == pbk_pkg::PBK_DATA_OFS[8])
    |=> pin_out[8] == $past(req_in.wdata))
    else $error("port 8 pins do not follow write");

  port8_read_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (req_in.wr && req_in.addr == pbk_pkg::PBK_DATA_OFS[8])
    ##1 (req_in.rd && req_in.addr == pbk_pkg::PBK_DATA_OFS[8])
    |=> rdata_out == $past(req_in.wdata, 2))
    else $error("port 8 read back differs from written value");

  analog_release_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (pin_oe_out[5] & analog_channel_sel_in) == 8'h00)
    else $error("port 5 drives a pin claimed by an analog channel");

  analog_drive_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (pin_oe_out[5] | analog_channel_sel_in) == 8'hFF)
    else $error("port 5 pin left undriven without analog use");

  // Register reads and latch writes
  wo_dir_read_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (req_in.rd && (req_in.addr == pbk_pkg::PBK_DIR_OFS[0]
    || req_in.addr == pbk_pkg::PBK_DIR_OFS[1])) |=> rdata_out == 8'h00)
    else $error("write-only direction register read back nonzero");

  rdata_idle_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    !req_in.rd |=> rdata_out == 8'h00)
    else $error("read data stands without a read");

  bit_op_read_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (req_in.rd && req_in.bit_op && req_in.addr == pbk_pkg::PBK_DATA_OFS[3])
    |=> rdata_out == $past(latch[3]))
    else $error("bit operation read did not return latch");

  pin_sync_read_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    $past(rstn_in, 3) && req_in.rd && !req_in.bit_op
    && req_in.addr == pbk_pkg::PBK_DATA_OFS[0]
    |=> rdata_out == $past(pin_in[0], 3))
    else $error("port 0 read not two stages behind pin");

  port9_read_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    $past(rstn_in, 3) && req_in.rd && !req_in.bit_op
    && req_in.addr == pbk_pkg::PBK_DATA_OFS[9]
    |=> rdata_out == $past(pin_in[9], 3))
    else $error("port 9 read does not return pin level");

  latch_write_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (req_in.wr && req_in.addr == pbk_pkg::PBK_DATA_OFS[1])
    |=> pin_out[1] == $past(req_in.wdata))
    else $error("port 1 latch not updated by write");

  latch_write_p0_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (req_in.wr && req_in.addr == pbk_pkg::PBK_DATA_OFS[0])
    |=> pin_out[0] == $past(req_in.wdata))
    else $error("port 0 latch not updated by write");

  // Shared pins
  periph_p3_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    ((pin_out[3] ^ periph_dout_in[3]) & periph_sel_in[3]
    & pbk_pkg::PBK_PERIPH_MASK[3]) == 8'h00
    && (~pin_oe_out[3] & periph_sel_in[3] & pbk_pkg::PBK_PERIPH_MASK[3]) == 8'h00)
    else $error("port 3 peripheral does not own its shared pins");

  plain_p3_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    ((pin_oe_out[3] ^ direction[3]) & ~pbk_pkg::PBK_PERIPH_MASK[3]) == 8'h00)
    else $error("port 3 unshared pin ignores its direction bit");

  periph_p6_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    ((pin_out[6] ^ periph_dout_in[6]) & periph_sel_in[6]
    & pbk_pkg::PBK_PERIPH_MASK[6]) == 8'h00
    && (~pin_oe_out[6] & periph_sel_in[6] & pbk_pkg::PBK_PERIPH_MASK[6]) == 8'h00)
    else $error("port 6 peripheral does not own its shared pins");

  plain_p6_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    ((pin_oe_out[6] ^ direction[6]) & ~pbk_pkg::PBK_PERIPH_MASK[6]) == 8'h00)
    else $error("port 6 unshared pin ignores its direction bit");

  periph_p7_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    ((pin_out[7] ^ periph_dout_in[7]) & periph_sel_in[7]
    & pbk_pkg::PBK_PERIPH_MASK[7]) == 8'h00
    && (~pin_oe_out[7] & periph_sel_in[7] & pbk_pkg::PBK_PERIPH_MASK[7]) == 8'h00)
    else $error("port 7 peripheral does not own its shared pins");

  plain_p7_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    ((pin_oe_out[7] ^ direction[7]) & ~pbk_pkg::PBK_PERIPH_MASK[7]) == 8'h00)
    else $error("port 7 unshared pin ignores its direction bit");

  // Synchronised pin levels
  sync_reset_a: assert property (@(posedge core_clk_in)
    !rstn_in |-> pin_sync_out == '0)
    else $error("synchronisers not cleared in reset");

  level_irq_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    $past(rstn_in, 2) && $past(rstn_in)
    |-> level_irq_out[7:0] == $past(pin_in[9], 2))
    else $error("level interrupt inputs do not follow port 9");

  edge_irq_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    $past(rstn_in, 2) && $past(rstn_in)
    |-> edge_irq_out == $past(pin_in[10], 2)
    && level_irq_out[15:8] == $past(pin_in[10], 2))
    else $error("interrupt inputs do not follow port A");

  serial_a_pin_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    $past(rstn_in, 2) && $past(rstn_in)
    |-> serial_a_in_out == $past(pin_in[3][6], 2))
    else $error("serial input does not follow its pin");

  counter_pin_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    $past(rstn_in, 2) && $past(rstn_in)
    |-> counter_ext_clock_out == $past(pin_in[6][1], 2)
    && buffered_serial_a_in_out == $past(pin_in[6][6], 2))
    else $error("port 6 resource inputs do not follow their pins");

  serial_b_pin_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    $past(rstn_in, 2) && $past(rstn_in)
    |-> serial_b_in_out == $past(pin_in[7][1], 2)
    && buffered_serial_b_in_out == $past(pin_in[7][4], 2))
    else $error("port 7 resource inputs do not follow their pins");

endmodule : pbk_port_bank

// File: tb/pbk_board.sv
`timescale 1ns/1ps
module pbk_board (
  // Pads from the bank
  input wire logic [10:0][7:0] pin_out_in,
  input wire logic [10:0][7:0] pin_oe_in,
  // Level the board holds on pins left floating
  input wire logic [10:0][7:0] board_in,
  // Pad levels seen by the bank
  output logic [10:0][7:0] pad_out
);
  // A driven pin shows the bank's level; a floating one the board's
  assign pad_out = (pin_out_in & pin_oe_in) | (board_in & ~pin_oe_in);
endmodule : pbk_board

// File: tb/test_parallel_io_port_bank.sv
`timescale 1ns/1ps
module test_parallel_io_port_bank;
  logic core_clk_in;
  logic rstn_in;
  pbk_pkg::pbk_req_t req;
  logic [7:0] rdata, asel, eirq;
  logic [15:0] lirq;
  logic [10:0][7:0] pads, pout, poe, psel, pdout, board, psync;
  logic sa, sb, bsa, bsb, cec;
  logic [7:0] dofs [4] = '{8'h0D, 8'h13, 8'h19, 8'h1B};
  int errors, checked;
  pbk_port_bank dut (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .req_in(req),
    .rdata_out(rdata), .pin_in(pads), .pin_out(pout), .pin_oe_out(poe),
    .periph_sel_in(psel), .periph_dout_in(pdout), .analog_channel_sel_in(asel),
    .pin_sync_out(psync), .serial_a_in_out(sa), .serial_b_in_out(sb),
    .buffered_serial_a_in_out(bsa), .buffered_serial_b_in_out(bsb),
    .counter_ext_clock_out(cec), .level_irq_out(lirq), .edge_irq_out(eirq));
  pbk_board board_model (.pin_out_in(pout), .pin_oe_in(poe), .board_in(board),
    .pad_out(pads));
  // ==========================================================
  // Clock and run limit
  initial begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end
  initial begin
    #200000;
    errors++;
    summarize();
  end
  // ==========================================================
  // Tasks
  task summarize;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk8
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, bit_op: 1'b0};
    @(posedge core_clk_in);
    req.wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, input logic bo, input logic [7:0] exp);
    @(posedge core_clk_in);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1, bit_op: bo};
    @(posedge core_clk_in);
    req.rd <= 1'b0;
    req.bit_op <= 1'b0;
    #1 chk8(rdata, exp);
  endtask : rd
  // Pin levels need two synchroniser edges before they read back
  task settle;
    repeat (3) @(posedge core_clk_in);
  endtask : settle
  // ==========================================================
  // Sequence
  initial begin
    errors = 0;
    checked = 0;
    req = '0;
    psel = '0;
    pdout = '0;
    asel = 8'h00;
    board = {11{8'h3C}};
    rstn_in = 1'b0;
    repeat (12) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    #1 chk8(poe[0], 8'h00);
    chk8(poe[2], 8'hFF);
    chk8(poe[4], 8'h1F);
    chk8(poe[8], 8'hFF);
    chk8(poe[5], 8'hFF);
    foreach (dofs[i]) begin
      rd(dofs[i], 1'b0, 8'h00);
      wr(dofs[i], 8'h5A);
      rd(dofs[i], 1'b0, 8'h5A);
      wr(dofs[i], 8'h00);
    end
    wr(8'h00, 8'h55);
    wr(8'h01, 8'h0F);
    settle();
    chk8(poe[0], 8'h0F);
    chk8(pout[0] & 8'h0F, 8'h05);
    rd(8'h00, 1'b0, 8'h35);
    rd(8'h00, 1'b1, 8'h55);
    rd(8'h01, 1'b0, 8'h00);
    rd(8'h05, 1'b0, 8'h00);
    wr(8'h0E, 8'hFF);
    rd(8'h0E, 1'b0, 8'h1F);
    wr(8'h04, 8'hC3);
    wr(8'h16, 8'h81);
    settle();
    chk8(pout[2], 8'hC3);
    rd(8'h04, 1'b0, 8'hC3);
    rd(8'h16, 1'b0, 8'h81);
    // Write then read with no idle cycle between the strobes
    @(posedge core_clk_in);
    req <= '{addr: 8'h16, wdata: 8'h7E, wr: 1'b1, rd: 1'b0, bit_op: 1'b0};
    @(posedge core_clk_in);
    req <= '{addr: 8'h16, wdata: 8'h00, wr: 1'b0, rd: 1'b1, bit_op: 1'b0};
    @(posedge core_clk_in);
    req <= '0;
    #1 chk8(rdata, 8'h7E);
    @(posedge core_clk_in);
    asel <= 8'h0F;
    board[3] <= 8'h7C;
    board[6] <= 8'h42;
    board[9] <= 8'h96;
    psel[3] <= 8'h01;
    pdout[3] <= 8'h01;
    psel[6] <= 8'h01;
    psel[7] <= 8'h08;
    settle();
    chk8(poe[5], 8'hF0);
    chk8(lirq[7:0], 8'h96);
    chk8(lirq[15:8], 8'h3C);
    chk8(eirq, 8'h3C);
    rd(8'h18, 1'b0, 8'h96);
    chk8(poe[3], 8'h01);
    chk8(pout[3] & 8'h01, 8'h01);
    chk8(psync[3], 8'h7D);
    chk8({7'h00, sa}, 8'h01);
    chk8(poe[6], 8'h01);
    chk8({6'h00, bsa, cec}, 8'h03);
    chk8(poe[7], 8'h08);
    chk8({6'h00, sb, bsb}, 8'h01);
    wr(8'h0D, 8'hA5);
    @(posedge core_clk_in);
    rstn_in <= 1'b0;
    @(posedge core_clk_in);
    #1 chk8(poe[0], 8'h00);
    chk8(poe[3], 8'h01);
    @(posedge core_clk_in);
    rstn_in <= 1'b1;
    rd(8'h0D, 1'b0, 8'h00);
    summarize();
  end
endmodule : test_parallel_io_port_bank
